/* include/summ_map.svh */
// Address map, field positions, fixed partition ranges and reset values of the segmented MMU.
`ifndef SUMM_MAP_SVH
`define SUMM_MAP_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SUMM_REG_CTRL 8'h00
`define SUMM_REG_TBASE 8'h04
`define SUMM_REG_STAT 8'h08
`define SUMM_REG_IRQ_STAT 8'h0c
`define SUMM_REG_IRQ_MASK 8'h10
`define SUMM_REG_FAULT_ADDR 8'h14
`define SUMM_REG_LOCK 8'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SUMM_CTRL_LOAD_BIT 0
`define SUMM_CTRL_NSEG_LSB 8
`define SUMM_IRQ_VIOL_BIT 0
`define SUMM_IRQ_COLL_BIT 1
`define SUMM_IRQ_LOADED_BIT 2
`define SUMM_LOCK_KEY 32'h7e57_0ff0
// ----------------------------------------
// Fixed partitioning: 24-bit physical space
// ----------------------------------------
`define SUMM_ROM_BASE 24'h00_0000
`define SUMM_ROM_SIZE 24'h04_0000
`define SUMM_RAM_BASE 24'h10_0000
`define SUMM_RAM_SIZE 24'h00_2000
`define SUMM_EE_BASE 24'h20_0000
`define SUMM_EE_SIZE 24'h02_4000
`define SUMM_EE_SECURE_BYTES 24'h00_0080
`define SUMM_EXC_VECTOR 24'h00_0008
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SUMM_RST_TBASE 24'h10_0000
`define SUMM_RST_NSEG 7'h00
`endif

/* include/summ_pkg.sv */
// Types shared by the segmented MMU.
package summ_pkg;
  typedef enum logic [2:0] {
    SUMM_MODE_USER = 3'b000,
    SUMM_MODE_SYSTEM = 3'b001,
    SUMM_MODE_BOOT = 3'b010,
    SUMM_MODE_TEST = 3'b011,
    SUMM_MODE_CLOS = 3'b100
  } summ_mode_t;
  typedef enum logic [1:0] {
    SUMM_ACC_READ = 2'b00,
    SUMM_ACC_WRITE = 2'b01,
    SUMM_ACC_FETCH = 2'b10
  } summ_acc_t;
  // Descriptor word: base[23:0] in word 0, size[23:0] in word 1,
  // {en, r, w, x, rights[7:0]} in word 2 bits 11:0.
  typedef struct packed {
    logic en;
    logic rd;
    logic wr;
    logic ex;
    logic [7:0] pfr_rights;
    logic [23:0] base;
    logic [23:0] size;
  } summ_seg_t;
  typedef struct packed {
    logic valid;
    summ_mode_t mode;
    summ_acc_t kind;
    logic pfr;
    logic [2:0] pfr_grp;
    logic [23:0] vaddr;
  } summ_req_t;
  typedef struct packed {
    logic valid;
    logic grant;
    logic [23:0] paddr;
  } summ_rsp_t;
  typedef enum logic [1:0] {
    SUMM_FS_IDLE = 2'b00,
    SUMM_FS_REQ = 2'b01,
    SUMM_FS_WAIT = 2'b10
  } summ_fs_t;
endpackage

/* logic/summ_mmu.sv */
// Segmented user mode MMU with descriptor fetch, access checks and Avalon-MM registers.
`include "summ_map.svh"
module summ_mmu import summ_pkg::*; #(
  parameter int NSEG = 64
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire summ_req_t cpu_req_i,
  output summ_rsp_t cpu_rsp_o,
  output logic exc_o,
  output logic [23:0] exc_vector_o,
  output logic force_system_o,
  input wire logic test_done_i,
  output logic test_mode_ok_o,
  output logic [23:0] fetch_addr_o,
  output logic fetch_req_o,
  input wire logic fetch_ack_i,
  input wire logic [31:0] fetch_data_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);
  localparam int IW = $clog2(NSEG);
  summ_seg_t seg_r [NSEG];
  logic [23:0] tbase_r;
  logic [6:0] nseg_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [23:0] fault_addr_r;
  logic test_fused_r;
  logic bus_ack_r;
  logic cpu_sys;
  summ_fs_t fs_r;
  logic [IW-1:0] fidx_r;
  logic [1:0] fword_r;
  logic [IW:0] cur_seg_r;
  logic load_go;
  logic done_pulse;
  logic wr_take;
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  // Configuration writes only count while the CPU itself runs privileged.
  // A write lands only at the edge where waitrequest is low, never earlier.
  assign cpu_sys = cpu_req_i.mode != SUMM_MODE_USER;
  assign wr_take = avs_write_i && bus_ack_r && cpu_sys;
  assign load_go = wr_take && fs_r == SUMM_FS_IDLE &&
    avs_address_i == `SUMM_REG_CTRL && avs_writedata_i[`SUMM_CTRL_LOAD_BIT];
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bus_ack_r <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      bus_ack_r <= (avs_read_i || avs_write_i) && !bus_ack_r;
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !bus_ack_r);
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tbase_r <= `SUMM_RST_TBASE;
      nseg_r <= `SUMM_RST_NSEG;
      irq_mask_r <= 3'h0;
    end else if (wr_take) begin
      case (avs_address_i)
        `SUMM_REG_CTRL: nseg_r <= avs_writedata_i[`SUMM_CTRL_NSEG_LSB +: 7];
        `SUMM_REG_TBASE: tbase_r <= avs_writedata_i[23:0];
        `SUMM_REG_IRQ_MASK: irq_mask_r <= avs_writedata_i[2:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && !bus_ack_r) begin
      case (avs_address_i)
        `SUMM_REG_CTRL: avs_readdata_o <= {17'h0, nseg_r, 8'h0};
        `SUMM_REG_TBASE: avs_readdata_o <= {8'h0, tbase_r};
        `SUMM_REG_STAT: avs_readdata_o <= {22'h0, test_fused_r, fs_r != SUMM_FS_IDLE,
          1'b0, cur_seg_r};
        `SUMM_REG_IRQ_STAT: avs_readdata_o <= {29'h0, irq_stat_r};
        `SUMM_REG_IRQ_MASK: avs_readdata_o <= {29'h0, irq_mask_r};
        `SUMM_REG_FAULT_ADDR: avs_readdata_o <= {8'h0, fault_addr_r};
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end
  // ----------------------------------------
  // Test mode fuse
  // ----------------------------------------
  // The fuse has no clearing path other than reset of the model; real silicon holds it in NVM.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      test_fused_r <= 1'b0;
      test_mode_ok_o <= 1'b1;
    end else if (test_done_i || (wr_take &&
        avs_address_i == `SUMM_REG_LOCK && avs_writedata_i == `SUMM_LOCK_KEY)) begin
      test_fused_r <= 1'b1;
      test_mode_ok_o <= 1'b0;
    end
  end
  // ----------------------------------------
  // Descriptor fetch
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fs_r <= SUMM_FS_IDLE;
      fidx_r <= '0;
      fword_r <= 2'h0;
      fetch_req_o <= 1'b0;
      fetch_addr_o <= 24'h0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      case (fs_r)
        SUMM_FS_IDLE: begin
          // The count written together with LOAD is the one that counts.
          if (load_go && avs_writedata_i[`SUMM_CTRL_NSEG_LSB +: 7] != 7'h0) begin
            fs_r <= SUMM_FS_REQ;
            fidx_r <= '0;
            fword_r <= 2'h0;
          end
        end
        SUMM_FS_REQ: begin
          fetch_req_o <= 1'b1;
          fetch_addr_o <= tbase_r + 24'(fidx_r) * 24'd12 +
            {20'h0, fword_r, 2'h0};
          fs_r <= SUMM_FS_WAIT;
        end
        SUMM_FS_WAIT: begin
          if (fetch_ack_i) begin
            fetch_req_o <= 1'b0;
            if (fword_r == 2'h2) begin
              fword_r <= 2'h0;
              if (7'(fidx_r) + 7'h1 >= nseg_r || 7'(fidx_r) == 7'(NSEG - 1)) begin
                fs_r <= SUMM_FS_IDLE;
                done_pulse <= 1'b1;
              end else begin
                fidx_r <= fidx_r + IW'(1);
                fs_r <= SUMM_FS_REQ;
              end
            end else begin
              fword_r <= fword_r + 2'h1;
              fs_r <= SUMM_FS_REQ;
            end
          end
        end
        default: fs_r <= SUMM_FS_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Segment table
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSEG; g++) begin : g_seg
      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          seg_r[g] <= '0;
        end else if (load_go) begin
          seg_r[g].en <= 1'b0;
        end else if (fs_r == SUMM_FS_WAIT && fetch_ack_i && fidx_r == IW'(g)) begin
          case (fword_r)
            2'h0: seg_r[g].base <= fetch_data_i[23:0];
            2'h1: seg_r[g].size <= fetch_data_i[23:0];
            default: {seg_r[g].en, seg_r[g].rd, seg_r[g].wr, seg_r[g].ex,
              seg_r[g].pfr_rights} <= fetch_data_i[11:0];
          endcase
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Lookup and check
  // ----------------------------------------
  logic [IW:0] hit_idx;
  logic hit_any;
  logic hit_two;
  always_comb begin
    hit_idx = '0;
    hit_any = 1'b0;
    hit_two = 1'b0;
    for (int i = 0; i < NSEG; i++) begin
      if (seg_r[i].en && cpu_req_i.vaddr >= seg_r[i].base &&
          cpu_req_i.vaddr - seg_r[i].base < seg_r[i].size) begin
        hit_two = hit_two | hit_any;
        if (!hit_any) begin
          hit_idx = (IW + 1)'(i);
        end
        hit_any = 1'b1;
      end
    end
  end
  // Fixed partition: ROM/RAM/EEPROM ranges are constants, never registers.
  logic [23:0] vaddr;
  logic in_part;
  logic in_secure;
  assign vaddr = cpu_req_i.vaddr;
  assign in_part = (vaddr >= `SUMM_ROM_BASE && vaddr < `SUMM_ROM_BASE + `SUMM_ROM_SIZE) ||
    (vaddr >= `SUMM_RAM_BASE && vaddr < `SUMM_RAM_BASE + `SUMM_RAM_SIZE) ||
    (vaddr >= `SUMM_EE_BASE && vaddr < `SUMM_EE_BASE + `SUMM_EE_SIZE);
  assign in_secure = vaddr >= `SUMM_EE_BASE + `SUMM_EE_SIZE - `SUMM_EE_SECURE_BYTES &&
    vaddr < `SUMM_EE_BASE + `SUMM_EE_SIZE;
  summ_seg_t hs;
  summ_seg_t cs;
  logic right_ok;
  logic pfr_ok;
  logic usr_ok;
  logic usr;
  logic viol;
  logic coll;
  assign hs = seg_r[hit_idx[IW-1:0]];
  assign cs = seg_r[cur_seg_r[IW-1:0]];
  assign usr = cpu_req_i.mode == SUMM_MODE_USER;
  assign right_ok = (cpu_req_i.kind == SUMM_ACC_READ && hs.rd) ||
    (cpu_req_i.kind == SUMM_ACC_WRITE && hs.wr) ||
    (cpu_req_i.kind == SUMM_ACC_FETCH && hs.ex);
  assign pfr_ok = !cur_seg_r[IW] && cs.pfr_rights[cpu_req_i.pfr_grp];
  // Reserved EEPROM rows stay out of user reach for non-PFR accesses even if a segment covers them.
  assign usr_ok = cpu_req_i.pfr ? pfr_ok :
    (hit_any && right_ok && in_part && !in_secure);
  assign coll = usr && !cpu_req_i.pfr && hit_two;
  // The contactless OS mode is never accepted from the request port.
  assign viol = cpu_req_i.mode == SUMM_MODE_CLOS || (usr && (!usr_ok || coll));
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cur_seg_r <= {1'b1, IW'(0)};
    end else if (cpu_req_i.valid && usr && cpu_req_i.kind == SUMM_ACC_FETCH && !viol) begin
      cur_seg_r <= hit_idx;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cpu_rsp_o <= '0;
    end else begin
      cpu_rsp_o.valid <= cpu_req_i.valid;
      cpu_rsp_o.grant <= cpu_req_i.valid && !viol;
      cpu_rsp_o.paddr <= vaddr;
    end
  end
  // ----------------------------------------
  // Exceptions and interrupts
  // ----------------------------------------
  logic fault;
  assign fault = cpu_req_i.valid && viol;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      exc_o <= 1'b0;
      force_system_o <= 1'b0;
      exc_vector_o <= 24'h0;
      fault_addr_r <= 24'h0;
    end else begin
      exc_o <= fault;
      force_system_o <= fault;
      exc_vector_o <= fault ? `SUMM_EXC_VECTOR : 24'h0;
      if (fault) begin
        fault_addr_r <= vaddr;
      end
    end
  end
  logic [2:0] ev;
  logic [2:0] clr;
  assign ev = {done_pulse, fault && coll, fault && !coll};
  assign clr = (wr_take &&
    avs_address_i == `SUMM_REG_IRQ_STAT) ? avs_writedata_i[2:0] : 3'h0;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_stat_r <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~clr) | ev;
      irq_o <= |(((irq_stat_r & ~clr) | ev) & irq_mask_r);
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SYS_GRANT: assert property (@(posedge clock_i) disable iff (srst_i)
    cpu_req_i.valid && cpu_req_i.mode == SUMM_MODE_SYSTEM |=> cpu_rsp_o.grant)
    else $error("System mode access was refused.");
  AST_EXC_ON_DENY: assert property (@(posedge clock_i) disable iff (srst_i)
    cpu_rsp_o.valid && !cpu_rsp_o.grant |-> exc_o && force_system_o &&
    exc_vector_o == `SUMM_EXC_VECTOR)
    else $error("Denied access raised no exception.");
  AST_NO_SEG_BLOCK: assert property (@(posedge clock_i) disable iff (srst_i)
    cpu_req_i.valid && usr && !cpu_req_i.pfr && !hit_any |=> !cpu_rsp_o.grant)
    else $error("Unmapped user access was granted.");
  AST_USER_CFG_LOCK: assert property (@(posedge clock_i) disable iff (srst_i)
    avs_write_i && !cpu_sys && bus_ack_r |=> $stable(tbase_r) && $stable(nseg_r) &&
    $stable(irq_mask_r))
    else $error("User mode changed the configuration.");
  AST_FUSE_STICKY: assert property (@(posedge clock_i) disable iff (srst_i)
    test_fused_r |=> test_fused_r && !test_mode_ok_o)
    else $error("Test mode came back.");
  AST_SECURE_ROWS: assert property (@(posedge clock_i) disable iff (srst_i)
    cpu_req_i.valid && usr && !cpu_req_i.pfr && in_secure |=> !cpu_rsp_o.grant ##0 exc_o)
    else $error("User reached the reserved EEPROM rows.");
  AST_RIGHTS: assert property (@(posedge clock_i) disable iff (srst_i)
    cpu_req_i.valid && usr && !cpu_req_i.pfr && hit_any && !right_ok |=> !cpu_rsp_o.grant)
    else $error("Segment rights were ignored.");
  AST_PFR_RIGHTS: assert property (@(posedge clock_i) disable iff (srst_i)
    cpu_req_i.valid && usr && cpu_req_i.pfr && !pfr_ok |=> !cpu_rsp_o.grant)
    else $error("Peripheral register access escaped the segment rights.");
  AST_CLOS_BLOCK: assert property (@(posedge clock_i) disable iff (srst_i)
    cpu_req_i.valid && cpu_req_i.mode == SUMM_MODE_CLOS |=> !cpu_rsp_o.grant)
    else $error("Contactless OS mode was accepted.");
  AST_BUS_ONE: assert property (@(posedge clock_i) disable iff (srst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Bus answer lasted too long.");
  AST_BUS_ANSWER: assert property (@(posedge clock_i) disable iff (srst_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("Bus request was not answered in time.");
  COV_LOAD: cover property (@(posedge clock_i) disable iff (srst_i) done_pulse);
  COV_USER_OK: cover property (@(posedge clock_i) disable iff (srst_i)
    cpu_req_i.valid && usr && !viol);
  COV_COLL: cover property (@(posedge clock_i) disable iff (srst_i) fault && coll);
  COV_IRQ: cover property (@(posedge clock_i) disable iff (srst_i) irq_o);
endmodule // summ_mmu

/* testbench/summ_mem_model.sv */
// Descriptor memory model that answers the MMU table fetch port.
module summ_mem_model (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic fetch_req_i,
  input wire logic [23:0] fetch_addr_i,
  input wire logic [3:0] delay_i,
  output logic fetch_ack_o,
  output logic [31:0] fetch_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [int];
  logic [3:0] cnt_r;
  // Idle data toggles every cycle so that a stale word never looks like an answer.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_r <= 4'h0;
      fetch_ack_o <= 1'b0;
      fetch_data_o <= 32'h5a5a_a5a5;
    end else if (fetch_req_i && !fetch_ack_o && cnt_r >= delay_i) begin
      fetch_ack_o <= 1'b1;
      fetch_data_o <= mem.exists(int'(fetch_addr_i)) ? mem[int'(fetch_addr_i)] : 32'h0;
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= (fetch_req_i && !fetch_ack_o) ? cnt_r + 4'h1 : 4'h0;
      fetch_ack_o <= 1'b0;
      fetch_data_o <= ~fetch_data_o;
    end
  end
endmodule // summ_mem_model

/* testbench/tb_top.sv */
// Self-checking bench for the segmented MMU with a descriptor memory model.
`include "summ_map.svh"
module tb_top import summ_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  summ_req_t req = '0;
  summ_rsp_t rsp;
  logic exc, frc, tok, freq, fack, wrq, irq;
  logic tdone = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [23:0] vec, faddr;
  logic [31:0] fdata, rdata, d;
  logic [31:0] wdata = 32'h0;
  logic [7:0] addr = 8'h00;
  logic [3:0] dly = 4'h0;
  int fails = 0, n_tests = 0, last_seg = -1, n, j;
  logic [23:0] sb [6] = '{24'h000000, 24'h100000, 24'h200000, 24'h100200, 24'h03f000, 24'h101000};
  logic [23:0] ss [6] = '{24'h001000, 24'h000400, 24'h024000, 24'h000100, 24'h002000, 24'h000100};
  logic [11:0] sf [6] = '{12'hd05, 12'he00, 12'hf00, 12'hc00, 12'hc00, 12'h700};
  summ_mode_t modes [6] = '{SUMM_MODE_USER, SUMM_MODE_USER, SUMM_MODE_SYSTEM, SUMM_MODE_BOOT,
    SUMM_MODE_TEST, SUMM_MODE_CLOS};
  summ_mmu #(.NSEG(64)) dut_u (.clock_i(clock_i), .srst_i(srst_i), .cpu_req_i(req),
    .cpu_rsp_o(rsp), .exc_o(exc), .exc_vector_o(vec), .force_system_o(frc),
    .test_done_i(tdone), .test_mode_ok_o(tok), .fetch_addr_o(faddr), .fetch_req_o(freq),
    .fetch_ack_i(fack), .fetch_data_i(fdata), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wrq), .irq_o(irq));
  summ_mem_model mem_u (.clock_i(clock_i), .srst_i(srst_i), .fetch_req_i(freq),
    .fetch_addr_i(faddr), .delay_i(dly), .fetch_ack_o(fack), .fetch_data_o(fdata));
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  // Random answer latency keeps the fetch engine from relying on a fixed delay.
  always @(posedge clock_i) dly <= 4'($urandom % 4);
  // ----------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dw);
    int k;
    @(posedge clock_i);
    addr <= a;
    wdata <= dw;
    rd <= !w;
    wr <= w;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (wrq !== 1'b0 && k < 50);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      fails++;
      print_verdict();
    end
  endtask
  function automatic summ_req_t mk(logic v, summ_mode_t m, summ_acc_t k, logic p,
      logic [2:0] g, logic [23:0] va);
    mk = '{valid: v, mode: m, kind: k, pfr: p, pfr_grp: g, vaddr: va};
  endfunction
  function automatic logic exp_grant(summ_req_t r, output int seg);
    int hits;
    logic inpart;
    hits = 0;
    seg = -1;
    if (r.mode != SUMM_MODE_USER) return r.mode != SUMM_MODE_CLOS;
    if (r.pfr) return last_seg >= 0 && sf[last_seg][r.pfr_grp];
    for (int i = 0; i < 6; i++)
      if (sf[i][11] && r.vaddr >= sb[i] && r.vaddr < sb[i] + ss[i]) begin
        hits++;
        if (seg < 0) seg = i;
      end
    inpart = r.vaddr < 24'h040000 || (r.vaddr >= 24'h100000 && r.vaddr < 24'h102000) ||
      (r.vaddr >= 24'h200000 && r.vaddr < 24'h223f80);
    if (hits != 1 || !inpart) return 1'b0;
    return sf[seg][10 - int'(r.kind)];
  endfunction
  task automatic acc(input summ_req_t r);
    logic g;
    int s;
    g = exp_grant(r, s);
    @(posedge clock_i);
    req <= r;
    @(posedge clock_i);
    req <= mk(1'b0, SUMM_MODE_SYSTEM, SUMM_ACC_READ, 1'b0, 3'h0, 24'h0);
    #1;
    check(rsp.valid, 1'b1);
    check(rsp.grant, g);
    check({exc, frc}, {2{!g}});
    check(vec, g ? 24'h0 : `SUMM_EXC_VECTOR);
    if (g) check(rsp.paddr, r.vaddr);
    if (g && r.mode == SUMM_MODE_USER && r.kind == SUMM_ACC_FETCH && !r.pfr) last_seg = s;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(99278));
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    req <= mk(1'b0, SUMM_MODE_SYSTEM, SUMM_ACC_READ, 1'b0, 3'h0, 24'h0);
    bus(0, `SUMM_REG_TBASE, 0);
    check(d, 32'h0010_0000);
    bus(0, 8'h40, 0);
    check(d, 32'h0);
    check(tok, 1'b1);
    $display("end of test reset");
    for (int i = 0; i < 6; i++) begin
      mem_u.mem[32'h101000 + 12 * i] = {8'h0, sb[i]};
      mem_u.mem[32'h101004 + 12 * i] = {8'h0, ss[i]};
      mem_u.mem[32'h101008 + 12 * i] = {20'h0, sf[i]};
    end
    bus(1, `SUMM_REG_TBASE, 32'h101000);
    req <= mk(1'b0, SUMM_MODE_USER, SUMM_ACC_READ, 1'b0, 3'h0, 24'h0);
    bus(1, `SUMM_REG_TBASE, 32'h222222);
    bus(1, `SUMM_REG_LOCK, `SUMM_LOCK_KEY);
    req <= mk(1'b0, SUMM_MODE_SYSTEM, SUMM_ACC_READ, 1'b0, 3'h0, 24'h0);
    bus(0, `SUMM_REG_TBASE, 0);
    check(d, 32'h101000);
    check(tok, 1'b1);
    bus(1, `SUMM_REG_CTRL, 32'h0601);
    n = 0;
    do begin
      bus(0, `SUMM_REG_IRQ_STAT, 0);
      n++;
    end while (d[2] !== 1'b1 && n < 200);
    check(d[2], 1'b1);
    bus(1, `SUMM_REG_IRQ_STAT, 32'h7);
    $display("end of test table load");
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_READ, 0, 0, 24'h223f7f));
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_READ, 0, 0, 24'h223f80));
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_READ, 0, 0, 24'h03ffff));
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_READ, 0, 0, 24'h040000));
    acc(mk(1, SUMM_MODE_SYSTEM, SUMM_ACC_WRITE, 0, 0, 24'h040000));
    acc(mk(1, SUMM_MODE_CLOS, SUMM_ACC_READ, 0, 0, 24'h100010));
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_READ, 0, 0, 24'h101010));
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_READ, 0, 0, 24'h100250));
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_FETCH, 0, 0, 24'h000100));
    for (int g = 0; g < 3; g++) acc(mk(1, SUMM_MODE_USER, SUMM_ACC_READ, 1, 3'(g), 0));
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_FETCH, 0, 0, 24'h200100));
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_READ, 1, 3'h0, 0));
    bus(0, `SUMM_REG_IRQ_STAT, 0);
    check(d[1:0], 2'h3);
    check(irq, 1'b0);
    $display("end of test corners");
    for (int i = 0; i < 80; i++) begin
      j = $urandom % 6;
      acc(mk(1, modes[$urandom % 6], summ_acc_t'($urandom % 3), 0, 0,
        sb[j] + 24'($urandom % 32'h1200) - 24'h8));
    end
    $display("end of test random");
    bus(1, `SUMM_REG_IRQ_STAT, 32'h7);
    bus(1, `SUMM_REG_IRQ_MASK, 32'h1);
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_WRITE, 0, 0, 24'h000200));
    repeat (2) @(posedge clock_i);
    check(irq, 1'b1);
    bus(0, `SUMM_REG_FAULT_ADDR, 0);
    check(d, 32'h000200);
    bus(1, `SUMM_REG_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clock_i);
    check(irq, 1'b0);
    $display("end of test interrupt");
    bus(1, `SUMM_REG_LOCK, 32'h0);
    check(tok, 1'b1);
    bus(1, `SUMM_REG_LOCK, `SUMM_LOCK_KEY);
    repeat (2) @(posedge clock_i);
    check(tok, 1'b0);
    bus(0, `SUMM_REG_STAT, 0);
    check(d[9], 1'b1);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    tdone <= 1'b1;
    for (int i = 0; i < 6; i++) sf[i][11] = 1'b0;
    last_seg = -1;
    @(posedge clock_i);
    tdone <= 1'b0;
    repeat (2) @(posedge clock_i);
    check(tok, 1'b0);
    acc(mk(1, SUMM_MODE_USER, SUMM_ACC_READ, 0, 0, 24'h100010));
    $display("end of test fuse");
    print_verdict();
  end
endmodule // tb_top
